// File: rtl/pfcgs_defs.svh
// Constants for the gate sequencing block: offsets, fields, timing.
`ifndef PFCGS_DEFS_SVH
`define PFCGS_DEFS_SVH

// Core clock rate and period.
`define PFCGS_CLK_HZ 10000000
`define PFCGS_CLK_NS 100

// Maximum frequency clamp options in hertz; least time, rounded up.
`define PFCGS_CLAMP_LO_HZ 131000
`define PFCGS_CLAMP_HI_HZ 250000
`define PFCGS_CLAMP_LO_CYC \
  ((`PFCGS_CLK_HZ + `PFCGS_CLAMP_LO_HZ - 1) / `PFCGS_CLAMP_LO_HZ)
`define PFCGS_CLAMP_HI_CYC \
  ((`PFCGS_CLK_HZ + `PFCGS_CLAMP_HI_HZ - 1) / `PFCGS_CLAMP_HI_HZ)

// Zero-current timeout, watchdog and enable filter in nanoseconds.
`define PFCGS_TOUT_NS 10000
`define PFCGS_TOUT_CYC (`PFCGS_TOUT_NS / `PFCGS_CLK_NS)
`define PFCGS_WDOG_NS 200000
`define PFCGS_WDOG_CYC (`PFCGS_WDOG_NS / `PFCGS_CLK_NS)
`define PFCGS_ENF_NS 100000
`define PFCGS_ENF_CYC (`PFCGS_ENF_NS / `PFCGS_CLK_NS)

// Disable timer options in milliseconds.
`define PFCGS_DIS0_MS 500
`define PFCGS_DIS1_MS 4000
`define PFCGS_DIS2_MS 13000
`define PFCGS_DIS0_CYC (`PFCGS_DIS0_MS * (`PFCGS_CLK_HZ / 1000))
`define PFCGS_DIS1_CYC (`PFCGS_DIS1_MS * (`PFCGS_CLK_HZ / 1000))
`define PFCGS_DIS2_CYC (`PFCGS_DIS2_MS * (`PFCGS_CLK_HZ / 1000))

// Supply hiccups needed before an auto restart.
`define PFCGS_HICCUPS 2'h3

// Register byte offsets.
`define PFCGS_CTRL_OFS 12'h000
`define PFCGS_STAT_OFS 12'h004

// Control register fields and reset value.
`define PFCGS_CTRL_CLAMP 0
`define PFCGS_CTRL_DIS_LO 1
`define PFCGS_CTRL_DIS_HI 2
`define PFCGS_CTRL_SKIP 3
`define PFCGS_CTRL_NLATCH 4
`define PFCGS_CTRL_RST 5'h00

// Status register fields.
`define PFCGS_ST_RUN 0
`define PFCGS_ST_PFC 1
`define PFCGS_ST_SKIP 2
`define PFCGS_ST_GATE 3
`define PFCGS_ST_TOK 4
`define PFCGS_ST_HIC_LO 5
`define PFCGS_ST_HIC_HI 6
`define PFCGS_ST_FSM_LO 7
`define PFCGS_ST_FSM_HI 8

`endif

// File: rtl/pfcgs_pkg.sv
// Types shared by the gate sequencing block.
package pfcgs_pkg;

  // Comparator and supervisor indications from the analog front end.
  typedef struct packed {
    logic zcd_trig;   // Zero-current detect trigger.
    logic on_end;     // On-time comparator ends the pulse.
    logic plev_low;   // Power level below disable reference.
    logic plev_high;  // Power level above reference plus hysteresis.
    logic ctl_low;    // Control voltage below skip threshold.
    logic ctl_high;   // Control voltage above skip plus hysteresis.
    logic vcc_on;     // Supply above its on threshold.
    logic vcc_low;    // Supply below its off threshold.
    logic vcc_reset;  // Supply below its reset threshold.
    logic brownout;   // Brown-out detected.
    logic line_ok;    // Line voltage present.
    logic overload;   // Flyback overload fault.
    logic overtemp;   // Junction above shutdown threshold.
    logic temp_cool;  // Junction below threshold minus hysteresis.
    logic uvp;        // Output undervoltage.
    logic regulated;  // Output has reached regulation.
    logic hard_ovp;   // Hard overvoltage.
    logic fb_short;   // Feedback input short.
    logic ss_done;    // Flyback soft start finished.
  } pfcgs_comp_t;

  // Controller supervisor states.
  typedef enum logic [1:0] {
    PF_OFF,
    PF_RUN,
    PF_HIC,
    PF_TSD
  } pfcgs_fsm_t;

  // Software control fields.
  typedef struct packed {
    logic       nonlatch;  // Overload leads to hiccup restart.
    logic       skip_en;   // Skip operation allowed.
    logic [1:0] dis_sel;   // Disable timer choice.
    logic       clamp_hi;  // Higher clamp frequency.
  } pfcgs_ctrl_t;

  // Synchroniser state.
  typedef struct packed {
    pfcgs_comp_t s1;
    pfcgs_comp_t s2;
  } pfcgs_sync_st_t;

  // Timer state.
  typedef struct packed {
    logic [27:0] cnt;
    logic        done;
  } pfcgs_tmr_st_t;

  // Top-level state.
  typedef struct packed {
    pfcgs_fsm_t  fsm;
    logic [1:0]  hic;
    logic        temp_ok;
    logic        ctl_on;
    logic        pfc_en;
    logic        skip;
    logic        reg_seen;
    logic        gate;
    logic        zcd_prev;
    logic        vcc_prev;
    pfcgs_ctrl_t ctrl;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } pfcgs_st_t;

endpackage

// File: rtl/pfcgs_sync.sv
// Two-stage synchroniser for the comparator inputs.
`timescale 1ns/1ns
`default_nettype none
module pfcgs_sync
  import pfcgs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire pfcgs_comp_t din,
  output var  pfcgs_comp_t dout
);

  pfcgs_sync_st_t q;  // Registered stages.
  pfcgs_sync_st_t d;  // Next stages.

  // The first stage feeds only the second stage.
  always_comb
  begin
    d = q;
    if (ce)
    begin
      d.s1 = din;
      d.s2 = q.s1;
    end
  end

  // Stages clear to zero under reset.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign dout = q.s2;

endmodule
`default_nettype wire

// File: rtl/pfcgs_timer.sv
// Cycle timer with a level run input and a sticky done flag.
`timescale 1ns/1ns
`default_nettype none
module pfcgs_timer
  import pfcgs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        clr,
  input  wire logic        run,
  input  wire logic [27:0] limit,
  output logic             done
);

  pfcgs_tmr_st_t q;  // Count and done flag.
  pfcgs_tmr_st_t d;  // Next count and flag.

  // Done rises limit cycles after run goes high; clr or a low run
  // restarts from zero.
  always_comb
  begin
    d = q;
    if (ce)
    begin
      if (clr || !run)
      begin
        d.cnt  = '0;
        d.done = 1'b0;
      end
      else if (!q.done)
      begin
        if (q.cnt >= limit - 28'h000_0001)
          d.done = 1'b1;
        else
          d.cnt = q.cnt + 28'h000_0001;
      end
    end
  end

  // State clears under reset.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign done = q.done;

endmodule
`default_nettype wire

// File: rtl/pfcgs_top.sv
// Power factor stage gate sequencing with fault recovery and APB.
//
// Summary of operation
// - No new pulse before clamp timer expires.
// - After clamp, start on zero-current edge.
// - Timeout starts pulse without zero-current edge.
// - Every zero-current edge restarts the timeout.
// - Load enable logic waits for soft start.
// - Low power level starts the disable timer.
// - Disable time is one of three options.
// - Expired disable timer stops the stage.
// - Re-enable after filtered high power level.
// - Skip suspends pulses below skip threshold.
// - Skip ends above threshold plus hysteresis.
// - Skip blocked at startup and undervoltage.
// - Supply off or overload: three hiccups.
// - Overtemperature disables and keeps supply hiccuping.
// - Cooled junction restarts at next supply-on.
// - Reset, brown-out or line loss clear thermal.
// - Fault-free restart at next supply-on.
// - Watchdog restarts each pulse, off on faults.
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "pfcgs_defs.svh"
module pfcgs_top
  import pfcgs_pkg::*;
#(
  parameter logic [27:0] DIS0_CYC = 28'(`PFCGS_DIS0_CYC),
  parameter logic [27:0] DIS1_CYC = 28'(`PFCGS_DIS1_CYC),
  parameter logic [27:0] DIS2_CYC = 28'(`PFCGS_DIS2_CYC)
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire pfcgs_comp_t comp_in,
  output logic             pfc_gate_out,
  output logic             ctl_on_out,
  output logic             pfc_en_out
);

  pfcgs_st_t   q;          // Registered state.
  pfcgs_st_t   d;          // Next state.
  pfcgs_comp_t s;          // Synchronised comparator inputs.
  logic        zcd_edge;   // New zero-current trigger.
  logic        vcc_rise;   // Supply crossed its on threshold.
  logic        clear_all;  // Reset, brown-out or line loss.
  logic        armed;      // Load-based enable logic active.
  logic        blocked;    // Pulses not allowed at all.
  logic        start;      // Begin a gate pulse now.
  logic        skip_ok;    // Skip gating allowed.
  logic        clamp_done; // Clamp timer expired.
  logic        tout_done;  // Timeout expired.
  logic        wd_done;    // Watchdog expired.
  logic        dis_done;   // Disable timer expired.
  logic        enf_done;   // Enable filter expired.
  logic [27:0] clamp_lim;  // Selected clamp count.
  logic [27:0] dis_lim;    // Selected disable count.
  logic        apb_acc;    // Access phase seen first time.
  logic [31:0] rd_word;    // Read data for the current address.
  logic        rd_bad;     // Address not mapped.

  // Every comparator indication is synchronised before use.
  pfcgs_sync u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .ce    (ce),
    .din   (comp_in),
    .dout  (s)
  );

  // Edge and level qualifiers derived from synchronised inputs.
  assign zcd_edge  = s.zcd_trig & ~q.zcd_prev;
  assign vcc_rise  = s.vcc_on & ~q.vcc_prev;
  assign clear_all = s.vcc_reset | s.brownout | ~s.line_ok;
  assign armed     = q.ctl_on & s.ss_done;

  // Pulses stop while off, disabled, skipping or in hard faults.
  assign blocked = ~q.ctl_on | ~q.pfc_en | q.skip
                 | s.hard_ovp | s.fb_short;

  // A pulse needs the clamp expired and a trigger.
  assign start = ~blocked & ~q.gate & clamp_done
               & (zcd_edge | tout_done | wd_done);

  // Skip gating only after regulation and outside undervoltage.
  assign skip_ok = q.ctrl.skip_en & q.reg_seen & ~s.uvp;

  // Clamp period choice.
  assign clamp_lim = q.ctrl.clamp_hi ? 28'(`PFCGS_CLAMP_HI_CYC)
                                     : 28'(`PFCGS_CLAMP_LO_CYC);

  // Disable time choice; the unused code takes the longest time.
  always_comb
  begin
    if (q.ctrl.dis_sel == 2'h0)
      dis_lim = DIS0_CYC;
    else if (q.ctrl.dis_sel == 2'h1)
      dis_lim = DIS1_CYC;
    else
      dis_lim = DIS2_CYC;
  end

  // Clamp timer runs from the start of each pulse.
  pfcgs_timer u_clamp (
    .clk   (pclk),
    .rst_n (presetn),
    .ce    (ce),
    .clr   (start),
    .run   (q.ctl_on),
    .limit (clamp_lim),
    .done  (clamp_done)
  );

  // Timeout restarts at each pulse and each zero-current edge.
  pfcgs_timer u_tout (
    .clk   (pclk),
    .rst_n (presetn),
    .ce    (ce),
    .clr   (start | zcd_edge),
    .run   (q.ctl_on),
    .limit (28'(`PFCGS_TOUT_CYC)),
    .done  (tout_done)
  );

  // Watchdog restarts at each pulse, held off in hard faults.
  pfcgs_timer u_wdog (
    .clk   (pclk),
    .rst_n (presetn),
    .ce    (ce),
    .clr   (start),
    .run   (q.ctl_on & ~s.hard_ovp & ~s.fb_short),
    .limit (28'(`PFCGS_WDOG_CYC)),
    .done  (wd_done)
  );

  // Disable timer runs only while the level stays low.
  pfcgs_timer u_dis (
    .clk   (pclk),
    .rst_n (presetn),
    .ce    (ce),
    .clr   (1'b0),
    .run   (armed & q.pfc_en & s.plev_low),
    .limit (dis_lim),
    .done  (dis_done)
  );

  // Enable filter needs an unbroken high level.
  pfcgs_timer u_enf (
    .clk   (pclk),
    .rst_n (presetn),
    .ce    (ce),
    .clr   (1'b0),
    .run   (armed & ~q.pfc_en & s.plev_high),
    .limit (28'(`PFCGS_ENF_CYC)),
    .done  (enf_done)
  );

  // Register read mux; unmapped addresses answer with an error.
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_bad  = 1'b0;
    if (paddr == `PFCGS_CTRL_OFS)
      rd_word[4:0] = q.ctrl;
    else if (paddr == `PFCGS_STAT_OFS)
    begin
      rd_word[`PFCGS_ST_RUN]  = q.ctl_on;
      rd_word[`PFCGS_ST_PFC]  = q.pfc_en;
      rd_word[`PFCGS_ST_SKIP] = q.skip;
      rd_word[`PFCGS_ST_GATE] = q.gate;
      rd_word[`PFCGS_ST_TOK]  = q.temp_ok;
      rd_word[`PFCGS_ST_HIC_HI:`PFCGS_ST_HIC_LO] = q.hic;
      rd_word[`PFCGS_ST_FSM_HI:`PFCGS_ST_FSM_LO] = q.fsm;
    end
    else
      rd_bad = 1'b1;
  end

  // Access phase in its first cycle; the answer follows one later.
  assign apb_acc = psel & penable & ~q.pready;

  // Next-state logic for supervisor, enables, skip, gate and bus.
  always_comb
  begin
    d = q;
    if (ce)
    begin
      d.zcd_prev = s.zcd_trig;
      d.vcc_prev = s.vcc_on;
      // Supervisor sequencing.
      case (q.fsm)
        PF_OFF:
        begin
          // Fresh power-up at supply-on unless the junction is still over temperature.
          if (vcc_rise && !s.overtemp)
            d.fsm = PF_RUN;
        end
        PF_RUN:
        begin
          if (s.overtemp)
          begin
            d.fsm     = PF_TSD;
            d.temp_ok = 1'b0;
          end
          else if (s.vcc_low || (q.ctrl.nonlatch && s.overload))
          begin
            d.fsm = PF_HIC;
            d.hic = 2'h0;
          end
        end
        PF_HIC:
        begin
          // Each return to supply-on completes one hiccup.
          if (s.overtemp)
          begin
            d.fsm     = PF_TSD;
            d.temp_ok = 1'b0;
          end
          else if (vcc_rise)
          begin
            if (q.hic == `PFCGS_HICCUPS - 2'h1)
              d.fsm = PF_RUN;
            else
              d.hic = q.hic + 2'h1;
          end
        end
        default:
        begin
          // Thermal fault: supply keeps hiccuping until cool.
          if (s.temp_cool && !s.overtemp)
            d.temp_ok = 1'b1;
          if (vcc_rise && (q.temp_ok || s.temp_cool) && !s.overtemp)
            d.fsm = PF_RUN;
        end
      endcase
      // Supply reset, brown-out or line loss clear every fault.
      if (clear_all)
      begin
        d.fsm     = PF_OFF;
        d.temp_ok = 1'b0;
        d.hic     = 2'h0;
      end
      d.ctl_on = (d.fsm == PF_RUN);
      // A fresh start enables the stage and forgets regulation.
      if (d.ctl_on && !q.ctl_on)
      begin
        d.pfc_en   = 1'b1;
        d.reg_seen = 1'b0;
      end
      else if (dis_done)
        d.pfc_en = 1'b0;
      else if (enf_done)
      begin
        d.pfc_en   = 1'b1;
        d.reg_seen = 1'b0;
      end
      else if (s.uvp)
        d.reg_seen = 1'b0;
      else if (s.regulated && q.pfc_en)
        d.reg_seen = 1'b1;
      // Skip hysteresis between the two control thresholds.
      if (!skip_ok)
        d.skip = 1'b0;
      else if (s.ctl_low)
        d.skip = 1'b1;
      else if (s.ctl_high)
        d.skip = 1'b0;
      // Gate drive.
      if (blocked)
        d.gate = 1'b0;
      else if (start)
        d.gate = 1'b1;
      else if (q.gate && s.on_end)
        d.gate = 1'b0;
      // Bus answer and register write.
      d.pready  = apb_acc;
      d.pslverr = apb_acc & rd_bad;
      if (apb_acc && !pwrite)
        d.prdata = rd_word;
      if (apb_acc && pwrite && paddr == `PFCGS_CTRL_OFS)
      begin
        d.ctrl.clamp_hi = pwdata[`PFCGS_CTRL_CLAMP];
        d.ctrl.dis_sel  = pwdata[`PFCGS_CTRL_DIS_HI:`PFCGS_CTRL_DIS_LO];
        d.ctrl.skip_en  = pwdata[`PFCGS_CTRL_SKIP];
        d.ctrl.nonlatch = pwdata[`PFCGS_CTRL_NLATCH];
      end
    end
  end

  // State register; all fields clear except the control reset value.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q      <= '0;
      q.fsm  <= PF_OFF;
      q.ctrl <= pfcgs_ctrl_t'(`PFCGS_CTRL_RST);
    end
    else
      q <= d;
  end

  // Outputs come straight from state flip-flops.
  assign prdata       = q.prdata;
  assign pready       = q.pready;
  assign pslverr      = q.pslverr;
  assign pfc_gate_out = q.gate;
  assign ctl_on_out   = q.ctl_on;
  assign pfc_en_out   = q.pfc_en;

  // A rising gate always follows an expired clamp.
  a_clamp_gap: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(q.gate) |-> $past(clamp_done))
    else $error("Gate rose before the clamp expired.");

  // A zero-current edge after the clamp starts a pulse.
  a_zcd_start: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !blocked && !q.gate && clamp_done && zcd_edge |=> q.gate)
    else $error("Zero-current edge did not start a pulse.");

  // Expired timeout after the clamp starts a pulse.
  a_tout_start: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !blocked && !q.gate && clamp_done && tout_done
    |=> q.gate)
    else $error("Timeout did not start a pulse.");

  // A zero-current edge restarts the timeout.
  a_tout_restart: assert property (@(posedge pclk) disable iff (!presetn)
    ce && zcd_edge |=> !tout_done)
    else $error("Timeout not restarted by zero-current edge.");

  // Nothing disables the stage before soft start ends.
  a_ss_hold: assert property (@(posedge pclk) disable iff (!presetn)
    ce && q.fsm == PF_RUN && !s.ss_done && q.pfc_en && !clear_all
    && !s.overtemp && !s.vcc_low && !s.overload |=> q.pfc_en)
    else $error("Stage disabled during soft start.");

  // Disable expiry turns the stage and then its gate off.
  a_dis_off: assert property (@(posedge pclk) disable iff (!presetn)
    ce && dis_done |=> !q.pfc_en ##1 !q.gate)
    else $error("Stage not turned off by disable timer.");

  // Skip needs prior regulation and holds the gate off from the next cycle.
  a_skip_gate: assert property (@(posedge pclk) disable iff (!presetn)
    ce && q.skip |-> $past(q.reg_seen) ##1 !q.gate)
    else $error("Gate active during skip or skip too early.");

  // Auto restart only after the third hiccup.
  a_hic_count: assert property (@(posedge pclk) disable iff (!presetn)
    ce && q.fsm == PF_HIC && d.fsm == PF_RUN |-> q.hic == 2'h2)
    else $error("Restart before three hiccups.");

  // Thermal fault keeps the controller off and the gate off next cycle.
  a_tsd_off: assert property (@(posedge pclk) disable iff (!presetn)
    ce && q.fsm == PF_TSD |-> !q.ctl_on ##1 !q.gate)
    else $error("Controller active in thermal fault.");

  // Each pulse start restarts the watchdog.
  a_wd_restart: assert property (@(posedge pclk) disable iff (!presetn)
    ce && start |=> !wd_done)
    else $error("Watchdog not restarted at pulse start.");

  // Hard overvoltage or a feedback short holds the watchdog off.
  a_wd_hold: assert property (@(posedge pclk) disable iff (!presetn)
    ce && (s.hard_ovp || s.fb_short) |=> !wd_done)
    else $error("Watchdog ran during a hard fault.");

endmodule
`default_nettype wire

// File: tb/pfcgs_front.sv
// Comparator front end and power switch model for the gate sequencing block.
`timescale 1ns/1ns
`default_nettype none
module pfcgs_front
  import pfcgs_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        gate,
  input  wire pfcgs_comp_t env,
  input  wire logic        zcd_on,
  input  wire logic [31:0] zcd_dly,
  output var  pfcgs_comp_t comp
);
  int on_n;   // Cycles the switch has been on.
  int off_n;  // Cycles the switch has been off.
  // The on comparator trips after ten on cycles; the winding rings once.
  always @(posedge pclk)
  begin
    on_n <= gate ? on_n + 1 : 0;
    off_n <= gate ? 0 : off_n + 1;
    comp <= env;
    comp.on_end <= gate && on_n >= 9;
    comp.zcd_trig <= zcd_on && !gate && off_n == zcd_dly;
  end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking testbench for the gate sequencing block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import pfcgs_pkg::*;
  localparam int DIS0_T = 50;   // Shortened disable counts.
  localparam int DIS1_T = 80;
  localparam int DIS2_T = 120;
  int dl;                       // Disable count under test.
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  pfcgs_comp_t comp_in;
  pfcgs_comp_t env = '0;
  logic        pfc_gate_out;
  logic        ctl_on_out;
  logic        pfc_en_out;
  logic        zcd_on = 0;
  int          zcd_dly = 5;
  logic [31:0] q;
  logic        e;
  int err_total, tests_run, gap, last_gap, rises, z, z2g, n;
  logic gprev;
  always #50 pclk = ~pclk;
  pfcgs_top #(.DIS0_CYC(28'(DIS0_T)), .DIS1_CYC(28'(DIS1_T)),
    .DIS2_CYC(28'(DIS2_T))) dut (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comp_in(comp_in), .pfc_gate_out(pfc_gate_out),
    .ctl_on_out(ctl_on_out), .pfc_en_out(pfc_en_out));
  pfcgs_front front (.pclk(pclk), .gate(pfc_gate_out), .env(env),
    .zcd_on(zcd_on), .zcd_dly(zcd_dly), .comp(comp_in));
  // Measures gaps between gate pulses and the zero-current response time.
  always @(posedge pclk)
  begin
    gprev <= pfc_gate_out;
    z <= comp_in.zcd_trig ? 0 : z + 1;
    gap <= gap + 1;
    if (pfc_gate_out === 1'b1 && gprev === 1'b0)
    begin
      last_gap <= gap;
      gap <= 1;
      rises <= rises + 1;
      z2g <= z;
    end
  end
  // Compares one value and reports a mismatch.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Waits a number of clock edges.
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  // One APB transfer: setup, access, then wait for pready.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1 && t < 50)
    begin
      @(posedge pclk);
      t++;
    end
    chk(t < 50, 1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  // One supply hiccup: down to the off level, then up to the on level.
  task automatic hiccup;
    env.vcc_on <= 0;
    env.vcc_low <= 1;
    cyc(6);
    env.vcc_low <= 0;
    env.vcc_on <= 1;
    cyc(6);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Cuts a hang short.
  initial
  begin
    #5000000;
    err_total++;
    stop_test();
  end
  // Main sequence.
  initial
  begin
    env.line_ok = 1;
    env.temp_cool = 1;
    cyc(5);
    presetn <= 1;
    cyc(1);
    chk({ctl_on_out, pfc_en_out, pfc_gate_out}, 0);
    apb(0, 12'h000, 0);
    chk(q, 0);
    apb(1, 12'h000, 32'h0000_001f);
    apb(0, 12'h000, 0);
    chk(q, 32'h0000_001f);
    apb(1, 12'h004, 32'h0000_ffff);
    chk(e, 0);
    apb(0, 12'h010, 0);
    chk({e, q}, {1'b1, 32'h0});
    apb(1, 12'h000, 32'h0000_0000);
    env.vcc_on <= 1;
    cyc(8);
    chk({ctl_on_out, pfc_en_out}, 2'b11);
    apb(0, 12'h004, 0);
    chk(q[8:7], 1);
    cyc(3000);
    chk(last_gap >= 100 && last_gap <= 103, 1);
    zcd_on <= 1;
    cyc(600);
    chk(last_gap >= 110 && last_gap <= 135, 1);
    chk(last_gap >= 77, 1);
    apb(1, 12'h000, 32'h0000_0001);
    zcd_dly <= 40;
    cyc(600);
    chk(z2g <= 3 && last_gap >= 40 && last_gap < 100, 1);
    zcd_dly <= 0;
    cyc(300);
    chk(last_gap >= 40, 1);
    apb(1, 12'h000, 32'h0000_0009);
    env.ctl_low <= 1;
    n = rises;
    cyc(400);
    chk(rises > n, 1);
    env.regulated <= 1;
    cyc(50);
    n = rises;
    cyc(400);
    chk(rises == n, 1);
    env.ctl_low <= 0;
    env.ctl_high <= 1;
    cyc(400);
    chk(rises > n, 1);
    env.uvp <= 1;
    env.ctl_high <= 0;
    env.ctl_low <= 1;
    n = rises;
    cyc(400);
    chk(rises > n, 1);
    env.uvp <= 0;
    env.ctl_low <= 0;
    env.plev_low <= 1;
    cyc(200);
    chk(pfc_en_out, 1);
    env.ss_done <= 1;
    cyc(30);
    env.plev_low <= 0;
    cyc(20);
    env.plev_low <= 1;
    cyc(30);
    chk(pfc_en_out, 1);
    env.plev_low <= 0;
    env.plev_high <= 1;
    cyc(20);
    for (int s = 0; s < 3; s++)
    begin
      apb(1, 12'h000, 32'(s << 1));
      env.plev_high <= 0;
      env.plev_low <= 1;
      dl = (s == 0) ? DIS0_T : (s == 1) ? DIS1_T : DIS2_T;
      cyc(dl - 15);
      chk(pfc_en_out, 1);
      cyc(30);
      chk(pfc_en_out, 0);
      n = rises;
      cyc(300);
      chk(rises, n);
      env.plev_low <= 0;
      env.plev_high <= 1;
      cyc(900);
      chk(pfc_en_out, 0);
      cyc(200);
      chk(pfc_en_out, 1);
    end
    env.vcc_on <= 0;
    env.vcc_low <= 1;
    cyc(6);
    chk(ctl_on_out, 0);
    for (int i = 1; i <= 3; i++)
    begin
      hiccup();
      chk(ctl_on_out, i == 3);
    end
    env.overtemp <= 1;
    env.temp_cool <= 0;
    cyc(6);
    chk({ctl_on_out, pfc_gate_out}, 0);
    hiccup();
    chk(ctl_on_out, 0);
    env.overtemp <= 0;
    env.temp_cool <= 1;
    hiccup();
    chk(ctl_on_out, 1);
    for (int f = 0; f < 3; f++)
    begin
      env.overtemp <= 1;
      env.temp_cool <= 0;
      cyc(6);
      env.vcc_reset <= (f == 0);
      env.brownout <= (f == 1);
      env.line_ok <= (f != 2);
      cyc(6);
      apb(0, 12'h004, 0);
      chk(q[8:7], 0);
      env.vcc_reset <= 0;
      env.brownout <= 0;
      env.line_ok <= 1;
      env.overtemp <= 0;
      env.temp_cool <= 1;
      hiccup();
      chk(ctl_on_out, 1);
    end
    apb(1, 12'h000, 32'h0000_0010);
    env.overload <= 1;
    cyc(6);
    chk(ctl_on_out, 0);
    env.overload <= 0;
    repeat (3) hiccup();
    chk(ctl_on_out, 1);
    env.hard_ovp <= 1;
    zcd_on <= 0;
    cyc(10);
    n = rises;
    cyc(2500);
    chk(rises, n);
    env.hard_ovp <= 0;
    env.fb_short <= 1;
    cyc(10);
    n = rises;
    cyc(300);
    chk(rises, n);
    stop_test();
  end
endmodule
`default_nettype wire
